// *** rtl/rail_fault_response.sv ***
/*
 * Fault reaction for the boost rail, two external sense inputs, the
 * internal regulator rail and the I/O supply: status bits, state
 * moves and the reset and drive-enable/interrupt pins.
 * Assumes raw comparator levels from the analog monitors and strobes
 * from the register logic for clearing status and releasing a state.
 */
`timescale 1ns/1ps
`default_nettype none

`include "rail_fault_params.svh"

module rail_fault_response #(
	parameter int RAIL_DEGLITCH_CYCLES = (`RAIL_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int INTERNAL_REGULATOR_RAIL_UV_CYCLES       = (`INTERNAL_REGULATOR_RAIL_UV_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int FAST_CYCLES          = (`FAST_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int OVP_OFF_CYCLES       = (`BOOST_OVP_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	// Raw comparator levels: 0 boostUv 1 boostOv 2 boostOvp 3..4 extUv
	// 5..6 extOv 7 vregUv 8 vregOv 9 ioOv
	input  wire logic [9:0]                 compRaw,
	// Configuration and software strobes
	input  wire rail_fault_pkg::railCfg_t   cfg,
	input  wire rail_fault_pkg::railStatus_t statusClear,
	input  wire logic                       stateRelease,
	// Status and state
	output var  rail_fault_pkg::railStatus_t status,
	output var  rail_fault_pkg::devState_t  deviceState,
	output var  logic                       boostEnable,
	// Pins, output enables active low
	output var  logic                       resetOutO,
	output var  logic                       resetOutOeN,
	output var  logic                       driveEnableIrqNO,
	output var  logic                       driveEnableIrqNOeN
);

	localparam int OW = $clog2(OVP_OFF_CYCLES + 1);
	localparam logic [OW-1:0] OVP_LAST = OW'(OVP_OFF_CYCLES - 1);

	typedef struct packed {
		rail_fault_pkg::devState_t   state;
		rail_fault_pkg::railStatus_t status;
		logic [9:0]                  faultPrev;
		logic                        ovpRun;
		logic [OW-1:0]               ovpTimer;
		logic                        boostEn;
		logic                        rstO;
		logic                        rstOeN;
		logic                        drvO;
		logic                        drvOeN;
	} topState_t;

	topState_t  r_q;
	topState_t  r_d;
	logic [9:0] fault;

	// ==========================================================
	// Deglitch filters, one per comparator channel
	for (genvar i = 0; i < 10; i++) begin : g_filt
		localparam int CYC = (i == 7) ? INTERNAL_REGULATOR_RAIL_UV_CYCLES :
			(i >= 8) ? FAST_CYCLES : RAIL_DEGLITCH_CYCLES;
		deglitch_filter #(
			.CYCLES (CYC)
		) u_filt (
			.clk      (clk),
			.reset_n  (reset_n),
			.compIn   (compRaw[i]),
			.faultOut (fault[i])
		);
	end

	// ==========================================================
	// Fault reaction
	logic [9:0] rise;
	logic [7:0] uvSet;
	logic [7:0] ovSet;
	logic [7:0] safSet;
	logic [7:0] extSet;
	logic       ovpTimeout;
	logic       goOff;
	logic       goReset;
	logic       goSafe;
	logic       rstLow;
	logic       drvLow;
	logic       ioDisc;

	always_comb begin
		r_d = r_q;
		rise = fault & ~r_q.faultPrev;
		r_d.faultPrev = fault;

		// Status bits latch the filtered level until cleared; set beats a clear
		uvSet = '0;
		ovSet = '0;
		safSet = '0;
		extSet = '0;
		uvSet[`UV_BIT_BOOST] = fault[0];
		uvSet[`UV_BIT_INTERNAL_REGULATOR_RAIL] = fault[7];
		ovSet[`OV_BIT_BOOST] = fault[1];
		ovSet[`OV_BIT_INTERNAL_REGULATOR_RAIL] = fault[8];
		ovSet[`OV_BIT_IO] = fault[9];
		safSet[`SAFETY_BIT_BOOST_OVP] = fault[2];
		extSet[`EXT_UV_LSB +: 2] = fault[4:3];
		extSet[`EXT_OV_LSB +: 2] = fault[6:5];
		r_d.status.railUndervoltage = (r_q.status.railUndervoltage & ~statusClear.railUndervoltage) | uvSet;
		r_d.status.railOvervoltage = (r_q.status.railOvervoltage & ~statusClear.railOvervoltage) | ovSet;
		r_d.status.boostSafety1 = (r_q.status.boostSafety1 & ~statusClear.boostSafety1) | safSet;
		r_d.status.externalMonitor = (r_q.status.externalMonitor & ~statusClear.externalMonitor) | extSet;

		// Boost OVP timer runs while the fault stays after disabling
		ovpTimeout = r_q.ovpRun && fault[2] && (r_q.ovpTimer == OVP_LAST);
		if (rise[2]) begin
			r_d.boostEn = 1'b0;
			r_d.ovpRun = 1'b1;
			r_d.ovpTimer = '0;
		end else if (r_q.ovpRun) begin
			if (!fault[2] || ovpTimeout) begin
				r_d.ovpRun = 1'b0;
			end else begin
				r_d.ovpTimer = r_q.ovpTimer + OW'(1);
			end
		end

		// Requests by severity; a boost UV without enable asks nothing
		goOff = rise[7] | rise[8] | ovpTimeout;
		goReset = (rise[0] & cfg.boostUvResetEnable)
			| (rise[1] & cfg.boostOvResetEnable)
			| (|(rise[4:3] & cfg.extUvResetEnable))
			| (|(rise[6:5] & cfg.extOvResetEnable));
		goSafe = (rise[1] & ~cfg.boostOvResetEnable)
			| rise[2]
			| (|(rise[4:3] & ~cfg.extUvResetEnable & cfg.extUvIrqEnable))
			| (|(rise[6:5] & ~cfg.extOvResetEnable & cfg.extOvIrqEnable));

		// OFF is final until power cycle; a fault never lowers severity
		unique case (r_q.state)
			rail_fault_pkg::ST_OFF: begin
				r_d.state = rail_fault_pkg::ST_OFF;
			end
			rail_fault_pkg::ST_RESET: begin
				if (goOff) begin
					r_d.state = rail_fault_pkg::ST_OFF;
				end else if (stateRelease && !goReset && !goSafe) begin
					r_d.state = rail_fault_pkg::ST_ACTIVE;
				end
			end
			rail_fault_pkg::ST_SAFE: begin
				if (goOff) begin
					r_d.state = rail_fault_pkg::ST_OFF;
				end else if (goReset) begin
					r_d.state = rail_fault_pkg::ST_RESET;
				end else if (stateRelease && !goSafe) begin
					r_d.state = rail_fault_pkg::ST_ACTIVE;
				end
			end
			rail_fault_pkg::ST_ACTIVE: begin
				if (goOff) begin
					r_d.state = rail_fault_pkg::ST_OFF;
				end else if (goReset) begin
					r_d.state = rail_fault_pkg::ST_RESET;
				end else if (goSafe) begin
					r_d.state = rail_fault_pkg::ST_SAFE;
				end
			end
		endcase

		// Boost stays off in OFF, and comes back only with the OVP gone
		if (r_d.state == rail_fault_pkg::ST_OFF) begin
			r_d.boostEn = 1'b0;
		end else if (r_d.state == rail_fault_pkg::ST_ACTIVE && !fault[2] && !r_q.ovpRun) begin
			r_d.boostEn = 1'b1;
		end

		// Pin levels from the next state
		rstLow = (r_d.state == rail_fault_pkg::ST_RESET) || (r_d.state == rail_fault_pkg::ST_OFF);
		drvLow = (r_d.state != rail_fault_pkg::ST_ACTIVE);
		ioDisc = fault[9];
		// A disconnected supply can only pull down, so a high pin floats
		r_d.rstO = ~rstLow & ~ioDisc;
		r_d.rstOeN = ioDisc & ~rstLow;
		r_d.drvO = ~drvLow & ~ioDisc;
		r_d.drvOeN = ioDisc & ~drvLow;
	end

	// ==========================================================
	// State register; reset leaves ACTIVE with both pins driven high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_q.state <= rail_fault_pkg::ST_ACTIVE;
			r_q.status <= {4{`STATUS_RESET}};
			r_q.faultPrev <= '0;
			r_q.ovpRun <= 1'b0;
			r_q.ovpTimer <= '0;
			r_q.boostEn <= 1'b1;
			r_q.rstO <= 1'b1;
			r_q.rstOeN <= 1'b0;
			r_q.drvO <= 1'b1;
			r_q.drvOeN <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs straight from the register
	assign status = r_q.status;
	assign deviceState = r_q.state;
	assign boostEnable = r_q.boostEn;
	assign resetOutO = r_q.rstO;
	assign resetOutOeN = r_q.rstOeN;
	assign driveEnableIrqNO = r_q.drvO;
	assign driveEnableIrqNOeN = r_q.drvOeN;

endmodule : rail_fault_response

`default_nettype wire

// *** rtl/rail_fault_params.svh ***
/*
 * Constants of the rail fault response: status bit positions, reset
 * values and timing figures. Assumes a 200 MHz core clock (5 ns period).
 */
`ifndef RAIL_FAULT_PARAMS_SVH
`define RAIL_FAULT_PARAMS_SVH

// ==========================================================
// Clock
`define CLK_PERIOD_NS        5

// ==========================================================
// Deglitch intervals and protection timing, in ns (least times)
`define RAIL_DEGLITCH_NS     21000
`define INTERNAL_REGULATOR_RAIL_UV_DEGLITCH_NS  24000
`define FAST_DEGLITCH_NS     10000
// Boost OVP off time; figure not given, plain default
`define BOOST_OVP_OFF_NS     1000000

// ==========================================================
// Status bit positions
`define UV_BIT_BOOST         3
`define UV_BIT_INTERNAL_REGULATOR_RAIL          4
`define OV_BIT_BOOST         3
`define OV_BIT_INTERNAL_REGULATOR_RAIL          4
`define OV_BIT_IO            7
`define SAFETY_BIT_BOOST_OVP 3
`define EXT_UV_LSB           0
`define EXT_OV_LSB           4

// ==========================================================
// Reset values
`define STATUS_RESET         8'h00

`endif

// *** rtl/rail_fault_pkg.sv ***
/*
 * Types of the rail fault response: device state, configuration group
 * and status group. Assumes rail_fault_params.svh for the constants.
 */
package rail_fault_pkg;

	// ==========================================================
	// Device state, Gray coded along ACTIVE-SAFE-RESET-OFF
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'h0,
		ST_SAFE   = 2'h1,
		ST_RESET  = 2'h3,
		ST_OFF    = 2'h2
	} devState_t;

	// ==========================================================
	// Fault reaction configuration
	typedef struct packed {
		logic       boostUvResetEnable;
		logic       boostOvResetEnable;
		logic [1:0] extUvResetEnable;
		logic [1:0] extUvIrqEnable;
		logic [1:0] extOvResetEnable;
		logic [1:0] extOvIrqEnable;
	} railCfg_t;

	// ==========================================================
	// Status registers (also used for the clear strobes)
	typedef struct packed {
		logic [7:0] railUndervoltage;
		logic [7:0] railOvervoltage;
		logic [7:0] boostSafety1;
		logic [7:0] externalMonitor;
	} railStatus_t;

endpackage : rail_fault_pkg

// *** rtl/deglitch_filter.sv ***
/*
 * One comparator channel: two-stage synchroniser followed by a
 * deglitch counter. Assumes the comparator output is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module deglitch_filter #(
	parameter int CYCLES = 4200,
	parameter int CW     = $clog2(CYCLES + 1)
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Comparator in, filtered fault out
	input  wire logic compIn,
	output var  logic faultOut
);

	typedef struct packed {
		logic          sync1;
		logic          sync2;
		logic [CW-1:0] count;
		logic          fault;
	} filtState_t;

	filtState_t r_q;
	filtState_t r_d;

	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	// ==========================================================
	// Fault only after the full interval; any drop restarts the count
	always_comb begin
		r_d       = r_q;
		r_d.sync1 = compIn;
		r_d.sync2 = r_q.sync1;
		if (!r_q.sync2) begin
			r_d.count = '0;
			r_d.fault = 1'b0;
		end else if (r_q.count == LAST) begin
			r_d.fault = 1'b1;
		end else begin
			r_d.count = r_q.count + CW'(1);
		end
	end

	// State register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign faultOut = r_q.fault;

endmodule : deglitch_filter

`default_nettype wire

// *** bench/rail_fault_response_monitor.sv ***
/* Checker on the ports of rail_fault_response.
   Assumes the package is compiled first; bound by the statement at the foot. */
`timescale 1ns/1ps
`default_nettype none
module rail_fault_response_monitor #(parameter int RAIL_DEGLITCH_CYCLES = 8) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Inputs watched
	input wire logic [9:0] compRaw,
	input wire rail_fault_pkg::railCfg_t cfg,
	// Outputs watched
	input wire rail_fault_pkg::railStatus_t status,
	input wire rail_fault_pkg::devState_t deviceState,
	input wire logic boostEnable,
	input wire logic resetOutO,
	input wire logic resetOutOeN,
	input wire logic driveEnableIrqNO,
	input wire logic driveEnableIrqNOeN
);
	// ==========================================================
	// Raw boost UV run length, held after the level falls so a late flag is still judged
	logic [15:0] runQ;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) runQ <= 16'h0;
		else if (compRaw[0]) runQ <= $past(compRaw[0]) ? runQ + 16'h1 : 16'h1;
	end
	// ==========================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence sUvRise; $rose(status.railUndervoltage[3]); endsequence
	sequence sOvpRise; $rose(status.boostSafety1[3]); endsequence
	a_uv_full_deglitch: assert property (sUvRise |-> runQ >= RAIL_DEGLITCH_CYCLES)
		else $error("boost UV flagged early");
	a_uv_reset_entry: assert property (sUvRise ##0 $past(cfg.boostUvResetEnable) |->
		deviceState inside {rail_fault_pkg::ST_RESET, rail_fault_pkg::ST_OFF}) else $error("no RESET on boost UV");
	a_uv_status_only: assert property (sUvRise ##0 !$past(cfg.boostUvResetEnable) |->
		$stable(deviceState) && $stable(resetOutO)) else $error("boost UV moved state");
	a_low_pins_held: assert property (deviceState inside {rail_fault_pkg::ST_RESET, rail_fault_pkg::ST_OFF} |->
		!resetOutO && !resetOutOeN && !driveEnableIrqNO && !driveEnableIrqNOeN) else $error("pins not low");
	a_safe_pin_levels: assert property (deviceState == rail_fault_pkg::ST_SAFE |->
		!driveEnableIrqNO && !driveEnableIrqNOeN && resetOutO != resetOutOeN) else $error("SAFE pins wrong");
	a_io_never_high: assert property ($rose(status.railOvervoltage[7]) |->
		!(resetOutO && !resetOutOeN) && !(driveEnableIrqNO && !driveEnableIrqNOeN)) else $error("pin driven high");
	a_io_state_kept: assert property ($rose(status.railOvervoltage[7]) |-> $stable(deviceState))
		else $error("I/O fault moved state");
	a_internal_regulator_rail_forces_off: assert property ($rose(status.railUndervoltage[4]) || $rose(status.railOvervoltage[4]) |->
		deviceState == rail_fault_pkg::ST_OFF) else $error("regulator fault not OFF");
	a_off_is_final: assert property ($past(deviceState) == rail_fault_pkg::ST_OFF |->
		deviceState == rail_fault_pkg::ST_OFF) else $error("OFF left");
	a_ovp_boost_off: assert property (sOvpRise |-> !boostEnable && deviceState != rail_fault_pkg::ST_ACTIVE)
		else $error("boost kept on");
endmodule : rail_fault_response_monitor
bind rail_fault_response rail_fault_response_monitor #(.RAIL_DEGLITCH_CYCLES(RAIL_DEGLITCH_CYCLES)) mon_u (.clk,
	.reset_n, .compRaw, .cfg, .status, .deviceState, .boostEnable, .resetOutO, .resetOutOeN,
	.driveEnableIrqNO, .driveEnableIrqNOeN);
`default_nettype wire

// *** bench/mcu_pin_model.sv ***
/* Microcontroller side of the reset and drive-enable/interrupt pins.
   Assumes pin value and active-low enable pairs from the block. */
`timescale 1ns/1ps
`default_nettype none
module mcu_pin_model (
	// Clock
	input wire logic clk,
	// Pins from the device
	input wire logic rO,
	input wire logic rOeN,
	input wire logic iO,
	input wire logic iOeN,
	// Levels the controller sees
	output var logic rLine,
	output var logic iLine
);
	// ==========================================================
	// No pull on these lines: a released line shows the inverse of its last level
	logic rLastQ = 1'h1;
	logic iLastQ = 1'h1;
	always_ff @(posedge clk) begin
		if (!rOeN) rLastQ <= rO;
		if (!iOeN) iLastQ <= iO;
	end
	assign rLine = rOeN ? ~rLastQ : rO;
	assign iLine = iOeN ? ~iLastQ : iO;
endmodule : mcu_pin_model
`default_nettype wire

// *** bench/rail_fault_response_test.sv ***
/* Table-driven bench for rail_fault_response with short deglitch counts.
   Assumes the monitor is bound and the pin model sits on the pins. */
`timescale 1ns/1ps
`default_nettype none
module rail_fault_response_test;
	// ==========================================================
	// Signals
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic [9:0] compRaw = 10'h000;
	rail_fault_pkg::railCfg_t cfg = '0;
	rail_fault_pkg::railStatus_t statusClear = '0;
	logic stateRelease = 1'h0;
	rail_fault_pkg::railStatus_t status;
	rail_fault_pkg::devState_t deviceState;
	logic boostEnable, rO, rOeN, iO, iOeN, rLine, iLine;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	// Fault bit, enables, status position and state code for each case
	int bitT [14] = '{0, 0, 1, 1, 2, 3, 4, 4, 6, 5, 5, 7, 8, 9};
	logic [9:0] cfgT [14] = '{10'h200, 10'h000, 10'h100, 10'h000, 10'h000, 10'h040, 10'h020,
		10'h010, 10'h008, 10'h001, 10'h008, 10'h3FF, 10'h000, 10'h000};
	int posT [14] = '{27, 27, 19, 19, 11, 0, 1, 1, 5, 4, 4, 28, 20, 23};
	logic [1:0] stT [14] = '{2'h3, 2'h0, 2'h3, 2'h1, 2'h1, 2'h3, 2'h1, 2'h0, 2'h3, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0};
	initial forever #2.5 clk = ~clk;
	// ==========================================================
	// Design and controller model
	rail_fault_response #(.RAIL_DEGLITCH_CYCLES(8), .INTERNAL_REGULATOR_RAIL_UV_CYCLES(8), .FAST_CYCLES(4), .OVP_OFF_CYCLES(20)) dut_u (
		.clk, .reset_n, .compRaw, .cfg, .statusClear, .stateRelease, .status, .deviceState, .boostEnable,
		.resetOutO(rO), .resetOutOeN(rOeN), .driveEnableIrqNO(iO), .driveEnableIrqNOeN(iOeN));
	mcu_pin_model mcu_u (.clk, .rO, .rOeN, .iO, .iOeN, .rLine, .iLine);
	// ==========================================================
	// Tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask : cycles
	task automatic doReset();
		reset_n = 1'h0;
		cycles(8);
		reset_n = 1'h1;
	endtask : doReset
	// High pins float while the I/O supply is lost; low pins stay driven
	task automatic checkPins(input logic [1:0] s, input logic io);
		logic rh, ih;
		rh = s == 2'h0 || s == 2'h1;
		ih = s == 2'h0;
		check("pins", {28'h0, rO, rOeN, iO, iOeN}, {28'h0, rh ? {~io, io} : 2'h0, ih ? {~io, io} : 2'h0});
		if (!io) check("lines", {30'h0, rLine, iLine}, {30'h0, rh, ih});
	endtask : checkPins
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			failures++;
			report_and_stop();
		end
	end
	// ==========================================================
	// Sequence
	initial begin
		doReset();
		cfg = '1;
		compRaw = 10'h081;
		cycles(5);
		compRaw = 10'h000;
		cycles(12);
		check("short pulse", status, 32'h0);
		checkPins(2'h0, 1'h0);
		$display("test glitch done");
		for (int k = 0; k < 14; k++) begin
			doReset();
			cfg = cfgT[k];
			compRaw[bitT[k]] = 1'h1;
			cycles(16);
			check("status", status, 32'h1 << posT[k]);
			check("state", 32'(deviceState), 32'(stT[k]));
			check("boostEnable", 32'(boostEnable), 32'(bitT[k] != 2 && stT[k] != 2'h2));
			checkPins(stT[k], bitT[k] == 9);
			compRaw = 10'h000;
			cycles(8);
			statusClear = '1;
			stateRelease = 1'h1;
			cycles(1);
			statusClear = '0;
			stateRelease = 1'h0;
			cycles(2);
			check("cleared", status, 32'h0);
			check("released", 32'(deviceState), stT[k] == 2'h2 ? 32'h2 : 32'h0);
			check("boost back", 32'(boostEnable), 32'(stT[k] != 2'h2));
			$display("test %0d done", k);
		end
		// A clear that meets a standing fault loses: the bit stays set
		doReset();
		compRaw = 10'h001;
		cycles(16);
		statusClear = '1;
		cycles(1);
		statusClear = '0;
		cycles(1);
		check("set wins", status, 32'h08000000);
		check("set wins state", 32'(deviceState), 32'h0);
		$display("test set wins done");
		doReset();
		compRaw = 10'h004;
		cycles(40);
		check("ovp off", 32'(deviceState), 32'h2);
		check("ovp boost", 32'(boostEnable), 32'h0);
		checkPins(2'h2, 1'h0);
		$display("test ovp timeout done");
		report_and_stop();
	end
endmodule : rail_fault_response_test
`default_nettype wire
